// ### rtl/pftr_byte_reg.sv
`timescale 1ns/1ps
`default_nettype none

// one staged byte: software writes the shadow, an update copies it to the active copy
module pftr_byte_reg #(
   parameter logic [7:0] MASK = 8'hFF       // bits that exist; others read zero
) (
   input  wire logic       clk_in,          // control clock
   input  wire logic       arst_n_in,       // async reset, active low
   input  wire logic       wr_in,           // write strobe for this byte
   input  wire logic [7:0] data_in,         // write data
   input  wire logic       update_in,       // copy shadow to active
   output logic      [7:0] shadow_out,      // value as written
   output logic      [7:0] active_out       // value the divider logic sees
);
   import pftr_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // masked bits never store, so they read back as zero
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shadow_out <= RESET_BYTE;
         active_out <= RESET_BYTE;
      end else begin
         if (wr_in) begin
            shadow_out <= data_in & MASK;
         end
         if (update_in) begin
            active_out <= shadow_out;
         end
      end
   end

endmodule : pftr_byte_reg

`default_nettype wire

// ### rtl/pftr_pkg.sv
package pftr_pkg;

   // ----------------------------------------------------------------
   // register offsets on the control port
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_UPDATE     = 16'h0005;  // update control register
   localparam logic [15:0] ADDR_REF_LOW    = 16'h0104;
   localparam logic [15:0] ADDR_REF_HIGH   = 16'h0105;
   localparam logic [15:0] ADDR_INT_DIV    = 16'h0106;
   localparam logic [15:0] ADDR_FRAC_LOW   = 16'h0107;
   localparam logic [15:0] ADDR_FRAC_MID   = 16'h0108;
   localparam logic [15:0] ADDR_FRAC_HIGH  = 16'h0109;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int          UPDATE_BIT      = 0;         // bit that issues the update
   localparam logic [7:0]  MASK_FULL       = 8'hFF;     // all eight bits stored
   localparam logic [7:0]  MASK_NIBBLE     = 8'h0F;     // only bits 3..0 stored
   localparam logic [7:0]  RESET_BYTE      = 8'h00;     // value of every byte after reset
   localparam logic [7:0]  READ_UNMAPPED   = 8'h00;     // answer to an unmapped read

   // ----------------------------------------------------------------
   // decode thresholds
   // ----------------------------------------------------------------
   localparam logic [11:0] REF_DOUBLE_VAL  = 12'h000;   // doubler code
   localparam logic [11:0] REF_DIVIDE_MIN  = 12'h004;   // first true divide value
   localparam logic [7:0]  INT_MIN_INTEGER = 8'h0F;     // 15, least divide in integer mode
   localparam logic [7:0]  INT_MIN_FRAC    = 8'h50;     // 80, least divide in fractional mode
   localparam logic [19:0] FRAC_INT_VAL    = 20'h00000; // fraction that selects integer mode

   // reference path selection
   typedef enum logic [1:0] {
      PFTR_REF_DOUBLE = 2'b00,
      PFTR_REF_BYPASS = 2'b01,
      PFTR_REF_DIVIDE = 2'b10
   } pftr_ref_mode_t;

endpackage : pftr_pkg

// ### rtl/pftr_regs.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Reference divider is 12 bits: low byte first, high nibble in next byte.
// - Reference divider value zero doubles the reference frequency.
// - Reference divider values one to three bypass the divider.
// - Reference divider values four to 4095 divide by that value.
// - Integer mode divides feedback by 15 to 255; lower values are illegal.
// - Fractional mode divides by 80 to 255; lower values are illegal.
// - Fraction word is 20 bits over three bytes; top nibble reserved.
// - Fraction zero selects integer mode, modulator off.
// - Nonzero fraction selects fractional mode, modulator on.
// - Written settings take effect when software writes one to update bit zero.
module pftr_regs (
   input  wire logic                    clk_in,          // control clock, 25 MHz
   input  wire logic                    arst_n_in,       // async reset, active low
   input  wire logic                    wr_en_in,        // byte write strobe
   input  wire logic                    rd_en_in,        // byte read strobe
   input  wire logic [15:0]             addr_in,         // register address
   input  wire logic [7:0]              wr_data_in,      // write data
   output logic      [7:0]              rd_data_out,     // read data, one cycle later
   output logic                         rd_valid_out,    // read data valid pulse
   output var pftr_pkg::pftr_ref_mode_t ref_mode_out,    // reference path mode
   output logic      [11:0]             ref_div_out,     // applied reference divider
   output logic      [7:0]              int_div_out,     // applied integer divider
   output logic      [19:0]             frac_word_out,   // applied fraction word
   output logic                         sdm_en_out,      // modulator enable
   output logic                         int_div_ok_out   // integer divider legal for mode
);
   import pftr_pkg::*;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire logic       update_w   = wr_en_in && (addr_in == ADDR_UPDATE)
                                 && wr_data_in[UPDATE_BIT];
   wire logic [5:0] wr_sel_w;
   assign wr_sel_w[0] = wr_en_in && (addr_in == ADDR_REF_LOW);
   assign wr_sel_w[1] = wr_en_in && (addr_in == ADDR_REF_HIGH);
   assign wr_sel_w[2] = wr_en_in && (addr_in == ADDR_INT_DIV);
   assign wr_sel_w[3] = wr_en_in && (addr_in == ADDR_FRAC_LOW);
   assign wr_sel_w[4] = wr_en_in && (addr_in == ADDR_FRAC_MID);
   assign wr_sel_w[5] = wr_en_in && (addr_in == ADDR_FRAC_HIGH);

   wire logic [7:0] shd_w [6];
   wire logic [7:0] act_w [6];

   // ----------------------------------------------------------------
   // staged byte registers
   // ----------------------------------------------------------------
   // high bytes keep only the low nibble so upper bits stay zero
   pftr_byte_reg #(.MASK(MASK_FULL))   u_ref_low (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .wr_in(wr_sel_w[0]), .data_in(wr_data_in),
      .update_in(update_w), .shadow_out(shd_w[0]), .active_out(act_w[0]));
   pftr_byte_reg #(.MASK(MASK_NIBBLE)) u_ref_high (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .wr_in(wr_sel_w[1]), .data_in(wr_data_in),
      .update_in(update_w), .shadow_out(shd_w[1]), .active_out(act_w[1]));
   pftr_byte_reg #(.MASK(MASK_FULL))   u_int_div (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .wr_in(wr_sel_w[2]), .data_in(wr_data_in),
      .update_in(update_w), .shadow_out(shd_w[2]), .active_out(act_w[2]));
   pftr_byte_reg #(.MASK(MASK_FULL))   u_frac_low (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .wr_in(wr_sel_w[3]), .data_in(wr_data_in),
      .update_in(update_w), .shadow_out(shd_w[3]), .active_out(act_w[3]));
   pftr_byte_reg #(.MASK(MASK_FULL))   u_frac_mid (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .wr_in(wr_sel_w[4]), .data_in(wr_data_in),
      .update_in(update_w), .shadow_out(shd_w[4]), .active_out(act_w[4]));
   pftr_byte_reg #(.MASK(MASK_NIBBLE)) u_frac_high (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .wr_in(wr_sel_w[5]), .data_in(wr_data_in),
      .update_in(update_w), .shadow_out(shd_w[5]), .active_out(act_w[5]));

   // ----------------------------------------------------------------
   // field assembly and decode
   // ----------------------------------------------------------------
   wire logic [11:0] ref_act_w  = {act_w[1][3:0], act_w[0]};
   wire logic [7:0]  int_act_w  = act_w[2];
   wire logic [19:0] frac_act_w = {act_w[5][3:0], act_w[4], act_w[3]};

   // fraction zero keeps the modulator off; any other value runs it
   wire logic        sdm_nxt    = (frac_act_w != FRAC_INT_VAL);

   // the doubler and bypass codes override the divide path
   wire pftr_ref_mode_t ref_mode_nxt =
      (ref_act_w == REF_DOUBLE_VAL) ? PFTR_REF_DOUBLE :
      (ref_act_w <  REF_DIVIDE_MIN) ? PFTR_REF_BYPASS :
                                      PFTR_REF_DIVIDE;

   // legality flag only reports; the value still goes to the divider as written
   wire logic        int_ok_nxt = sdm_nxt ? (int_act_w >= INT_MIN_FRAC)
                                          : (int_act_w >= INT_MIN_INTEGER);

   // read mux returns the shadow so software sees what it wrote
   wire logic [7:0]  rd_nxt =
      (addr_in == ADDR_REF_LOW)   ? shd_w[0] :
      (addr_in == ADDR_REF_HIGH)  ? shd_w[1] :
      (addr_in == ADDR_INT_DIV)   ? shd_w[2] :
      (addr_in == ADDR_FRAC_LOW)  ? shd_w[3] :
      (addr_in == ADDR_FRAC_MID)  ? shd_w[4] :
      (addr_in == ADDR_FRAC_HIGH) ? shd_w[5] : READ_UNMAPPED;

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   // one cycle of latency after the active copy changes; outputs stay glitch free
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ref_mode_out   <= PFTR_REF_DOUBLE;
         ref_div_out    <= REF_DOUBLE_VAL;
         int_div_out    <= RESET_BYTE;
         frac_word_out  <= FRAC_INT_VAL;
         sdm_en_out     <= 1'b0;
         int_div_ok_out <= 1'b0;
      end else begin
         ref_mode_out   <= ref_mode_nxt;
         ref_div_out    <= ref_act_w;
         int_div_out    <= int_act_w;
         frac_word_out  <= frac_act_w;
         sdm_en_out     <= sdm_nxt;
         int_div_ok_out <= int_ok_nxt;
      end
   end

   // read answer
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out  <= READ_UNMAPPED;
         rd_valid_out <= 1'b0;
      end else begin
         rd_data_out  <= rd_en_in ? rd_nxt : READ_UNMAPPED;
         rd_valid_out <= rd_en_in;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);

   sequence s_write_ref_high;
      wr_en_in && (addr_in == ADDR_REF_HIGH);
   endsequence
   sequence s_update;
      update_w;
   endsequence
   sequence s_read;
      rd_en_in;
   endsequence

   // shadow fields as the next update will apply them
   wire logic [11:0] ref_shd_w  = {shd_w[1][3:0], shd_w[0]};
   wire logic [7:0]  int_shd_w  = shd_w[2];
   wire logic [19:0] frac_shd_w = {shd_w[5][3:0], shd_w[4], shd_w[3]};
   // divider bytes only; the update register reads zero like an unmapped place
   wire logic        map_hit_w  = (addr_in >= ADDR_REF_LOW) && (addr_in <= ADDR_FRAC_HIGH);

   a_ref_pack: assert property (
      (s_write_ref_high ##1 s_update) |=> (ref_act_w[11:8] == $past(wr_data_in[3:0], 2))
      ##1 (ref_div_out[11:8] == $past(ref_act_w[11:8])))
      else $error("reference high nibble not applied");
   a_ref_double: assert property (
      (ref_act_w == 12'h000) |=> (ref_mode_out == PFTR_REF_DOUBLE))
      else $error("zero reference value does not double");
   a_ref_bypass: assert property (
      (ref_act_w >= 12'h001 && ref_act_w <= 12'h003) |=> (ref_mode_out == PFTR_REF_BYPASS))
      else $error("reference bypass code not decoded");
   a_ref_divide: assert property (
      (ref_act_w >= 12'h004) |=> (ref_mode_out == PFTR_REF_DIVIDE)
      && (ref_div_out == $past(ref_act_w)))
      else $error("reference divide value wrong");
   a_int_legal: assert property (
      (frac_act_w == 20'h00000) |=> (int_div_ok_out == ($past(int_act_w) >= 8'h0F)))
      else $error("integer mode legality wrong");
   a_frac_legal: assert property (
      (frac_act_w != 20'h00000) |=> (int_div_ok_out == ($past(int_act_w) >= 8'h50)))
      else $error("fractional mode legality wrong");
   a_frac_pack: assert property (
      (wr_en_in && addr_in == ADDR_FRAC_HIGH) ##1 s_update
      |=> (frac_act_w[19:16] == $past(wr_data_in[3:0], 2)))
      else $error("fraction high nibble not applied");
   a_sdm_off: assert property (
      (frac_act_w == 20'h00000) |=> !sdm_en_out)
      else $error("modulator on with zero fraction");
   a_sdm_on: assert property (
      (frac_act_w != 20'h00000) |=> sdm_en_out)
      else $error("modulator off with nonzero fraction");
   a_update_hold: assert property (
      !update_w |=> $stable(ref_act_w) && $stable(int_act_w) && $stable(frac_act_w))
      else $error("active settings changed without update");
   a_reserved_zero: assert property (
      rd_en_in && (addr_in == ADDR_REF_HIGH || addr_in == ADDR_FRAC_HIGH)
      |=> (rd_data_out[7:4] == 4'h0))
      else $error("reserved bits read nonzero");

   // the update copies every staged byte in one edge, so the fields never tear
   a_update_copy: assert property (
      s_update |=> (ref_act_w == $past(ref_shd_w)) && (int_act_w == $past(int_shd_w))
      && (frac_act_w == $past(frac_shd_w)))
      else $error("update did not copy all staged bytes");
   // staged value reaches the divider outputs two edges after the update, unclamped
   a_int_pass: assert property (
      s_update |-> ##2 (int_div_out == $past(int_shd_w, 2)))
      else $error("integer divider not passed as written");
   a_frac_pass: assert property (
      s_update |-> ##2 (frac_word_out == $past(frac_shd_w, 2)))
      else $error("fraction word not passed as written");

   // a read answers exactly one edge later and the answer stands for that cycle only
   a_read_valid: assert property (
      s_read |=> rd_valid_out)
      else $error("read not answered");
   a_read_idle: assert property (
      !rd_en_in |=> !rd_valid_out && (rd_data_out == READ_UNMAPPED))
      else $error("read answer outside a read");
   // reads show the staged byte, not the applied one
   a_read_shadow: assert property (
      (rd_en_in && addr_in == ADDR_REF_LOW) |=> (rd_data_out == $past(shd_w[0])))
      else $error("low reference byte read wrong");
   a_read_unmapped: assert property (
      (rd_en_in && !map_hit_w) |=> (rd_data_out == READ_UNMAPPED))
      else $error("unmapped read not zero");

endmodule : pftr_regs

`default_nettype wire

// ### tb/pftr_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module pftr_regs_bench;
   import pftr_pkg::*;

   // ---------------------------------------------------------------
   // stimulus table and design
   // ---------------------------------------------------------------
   typedef struct {
      logic [11:0]    ref_v;
      logic [7:0]     int_v;
      logic [19:0]    frac_v;
      pftr_ref_mode_t mode;
      logic           sdm;
      logic           ok;
   } pftr_row_t;

   // boundary codes of each divider range; last row leaves ref at 4095
   // fractions stay below 0xFFFFF so a larger legal modulus always exists
   pftr_row_t rows [5] = '{
      '{12'h000, 8'h0F, 20'h00000, PFTR_REF_DOUBLE, 1'b0, 1'b1},
      '{12'h001, 8'h0E, 20'h00000, PFTR_REF_BYPASS, 1'b0, 1'b0},
      '{12'h003, 8'h50, 20'h00001, PFTR_REF_BYPASS, 1'b1, 1'b1},
      '{12'h004, 8'h4F, 20'hFFFFE, PFTR_REF_DIVIDE, 1'b1, 1'b0},
      '{12'hFFF, 8'hFF, 20'h10000, PFTR_REF_DIVIDE, 1'b1, 1'b1}};

   logic           clk_in      = 1'b0;
   logic           arst_n_in   = 1'b0;
   logic           wr_en_in    = 1'b0;
   logic           rd_en_in    = 1'b0;
   logic [15:0]    addr_in     = 16'h0000;
   logic [7:0]     wr_data_in  = 8'h00;
   logic [7:0]     rd_data_out;
   logic           rd_valid_out;
   pftr_ref_mode_t ref_mode_out;
   logic [11:0]    ref_div_out;
   logic [7:0]     int_div_out;
   logic [19:0]    frac_word_out;
   logic           sdm_en_out;
   logic           int_div_ok_out;
   int             n_fail      = 0;
   int             comparisons = 0;
   int             cycles      = 0;

   pftr_regs DUT (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
      .rd_valid_out(rd_valid_out), .ref_mode_out(ref_mode_out), .ref_div_out(ref_div_out),
      .int_div_out(int_div_out), .frac_word_out(frac_word_out), .sdm_en_out(sdm_en_out),
      .int_div_ok_out(int_div_ok_out));

   always #20 clk_in = ~clk_in;

   // cut a hang short; the whole run needs well under a thousand cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         $display("ERROR %0t: timeout", $time);
         test_done();
      end
   end

   // ---------------------------------------------------------------
   // bus tasks, all entered on a falling edge
   // ---------------------------------------------------------------
   task automatic test_done();
      if (n_fail == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // strobe stays high so writes can run back to back; bus_idle drops it
   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      wr_en_in   = 1'b1;
      addr_in    = a;
      wr_data_in = d;
      @(negedge clk_in);
   endtask : bus_wr

   task automatic bus_idle();
      wr_en_in = 1'b0;
      @(negedge clk_in);
   endtask : bus_idle

   // answer stands one cycle only, so it is looked at on the next falling edge
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      rd_en_in = 1'b1;
      addr_in  = a;
      @(negedge clk_in);
      rd_en_in = 1'b0;
      chk(rd_valid_out, 1'b1);
      chk(rd_data_out, exp);
      @(negedge clk_in);
      chk(rd_valid_out, 1'b0);
      chk(rd_data_out, 8'h00);
   endtask : rd

   // garbage in the reserved nibbles must never reach the outputs
   task automatic apply(input pftr_row_t r);
      bus_wr(ADDR_REF_LOW, r.ref_v[7:0]);
      bus_wr(ADDR_REF_HIGH, {4'hA, r.ref_v[11:8]});
      bus_wr(ADDR_INT_DIV, r.int_v);
      bus_wr(ADDR_FRAC_LOW, r.frac_v[7:0]);
      bus_wr(ADDR_FRAC_MID, r.frac_v[15:8]);
      bus_wr(ADDR_FRAC_HIGH, {4'h5, r.frac_v[19:16]});
      bus_wr(ADDR_UPDATE, 8'h01);
      bus_idle();
      @(negedge clk_in);
   endtask : apply

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(negedge clk_in);
      chk(ref_div_out, 12'h000);
      chk(sdm_en_out, 1'b0);
      arst_n_in = 1'b1;
      for (int i = 0; i < 5; i++) begin
         apply(rows[i]);
         chk(ref_div_out, rows[i].ref_v);
         chk(ref_mode_out, rows[i].mode);
         chk(int_div_out, rows[i].int_v);
         chk(frac_word_out, rows[i].frac_v);
         chk(sdm_en_out, rows[i].sdm);
         chk(int_div_ok_out, rows[i].ok);
         rd(ADDR_REF_HIGH, {4'h0, rows[i].ref_v[11:8]});
         rd(ADDR_FRAC_HIGH, {4'h0, rows[i].frac_v[19:16]});
      end
      // staged byte and an update write with bit zero clear change nothing
      bus_wr(ADDR_REF_LOW, 8'h21);
      bus_wr(ADDR_UPDATE, 8'hFE);
      bus_idle();
      repeat (2) @(negedge clk_in);
      chk(ref_div_out, 12'hFFF);
      rd(ADDR_REF_LOW, 8'h21);
      // high nibble written right before the update; the reserved C must be dropped
      bus_wr(ADDR_REF_HIGH, 8'hC2);
      bus_wr(ADDR_UPDATE, 8'h01);
      bus_idle();
      @(negedge clk_in);
      chk(ref_div_out, 12'h221);
      // unmapped place and the write-only update register read zero
      bus_wr(16'h0110, 8'h77);
      bus_idle();
      rd(16'h0110, 8'h00);
      rd(ADDR_UPDATE, 8'h00);
      // second reset in mid-run clears the applied settings
      arst_n_in = 1'b0;
      @(negedge clk_in);
      chk(ref_div_out, 12'h000);
      chk(frac_word_out, 20'h00000);
      arst_n_in = 1'b1;
      // two edges after release the cleared settings still decode as reset values
      repeat (2) @(negedge clk_in);
      chk(ref_mode_out, PFTR_REF_DOUBLE);
      chk(sdm_en_out, 1'b0);
      chk(int_div_ok_out, 1'b0);
      rd(ADDR_INT_DIV, 8'h00);
      test_done();
   end

endmodule : pftr_regs_bench

`default_nettype wire
